// ### pkg/shs_map.svh
// constants of the servo homing sequencer: offsets, fields, resets, timing
//
// Overview of operation
// - creep reverse: back off, re-approach at creep
// - normal finish loads home coordinate into position
// - nonzero window gates complete around home
// - zero window: complete always on after homing
// - travel limit in homing: timed deceleration
// - reaction 1: stop on third torque limit
// - preset input loads preset value into position
// - interrupt input latches position, travels set amount
// - stopper settings used only when reference is 5
// - stopper contact: detect time and torque limit
// - reaction 0: reverse at first limit, continue
// - reaction 1: cancel homing and stop
// - decode shift reference selection, default index
// - decode deceleration reference selection, default switch
// - switch edge: 0 assertion, 1 release
// - start direction forward, reverse or judged
// - marked settings apply only after restart; code applies them on a CTRL write with the reload bit set while idle
// - request rising edge starts search at homing speed
// - after reference, travel shift amount, stop, complete
// - no reference in reverse travel: resume start direction; code resumes forward for start direction 0 and reverse for all others
`ifndef SHS_MAP_SVH
`define SHS_MAP_SVH
`define SHS_CLK_HZ 40000000
`define SHS_MS_CYC (`SHS_CLK_HZ / 1000)
`define SHS_TENTH_MS_CYC (`SHS_CLK_HZ / 10000)
`define SHS_OFS_CTRL 8'h00
`define SHS_OFS_CFG 8'h04
`define SHS_OFS_HOME 8'h08
`define SHS_OFS_WIN 8'h0c
`define SHS_OFS_DECEL 8'h10
`define SHS_OFS_PRESET 8'h14
`define SHS_OFS_INTAMT 8'h18
`define SHS_OFS_STPTIME 8'h1c
`define SHS_OFS_STPTRQ 8'h20
`define SHS_OFS_SHIFT 8'h24
`define SHS_OFS_REVAMT 8'h28
`define SHS_OFS_STATUS 8'h2c
`define SHS_OFS_POS 8'h30
`define SHS_CTRL_REQ 0
`define SHS_CTRL_RELOAD 1
`define SHS_CTRL_INTARM 2
`define SHS_CFG_RESET 11'h004
`define SHS_DECEL_RESET 32'h0000_03e8
`define SHS_SHIFT_RESET 32'h0000_03e8
`define SHS_INTAMT_RESET 32'h0001_86a0
`define SHS_BACKUP_MARGIN 32'sh0000_0010
`endif

// ### pkg/shs_pkg.sv
// types of the servo homing sequencer
package shs_pkg;
  typedef enum logic [1:0] {TRQ_NORMAL, TRQ_THIRD, TRQ_STOPPER} shs_torque_e;
  typedef enum logic [2:0] {REF_SWITCH, REF_INDEX, REF_POS_LIMIT, REF_NEG_LIMIT, REF_INTERRUPT,
                            REF_STOPPER} shs_shift_ref_e;
  typedef enum {ST_IDLE, ST_REVERSE, ST_SEARCH, ST_CREEP, ST_BACKUP, ST_SHIFT, ST_LIMIT_DECEL,
                ST_INTPOS} shs_state_e;
  typedef struct packed {
    logic limitReaction;
    logic creepReverse;
    logic switchEdge;
    logic homingDir;
    logic [1:0] decelRef;
    logic [2:0] shiftRef;
    logic [1:0] startDir;
  } shs_cfg_s;
endpackage

// ### verilog/shs_homing_sequencer.sv
// homing and position reference sequencer with apb register access
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "shs_map.svh"
module shs_homing_sequencer
  import shs_pkg::*;
#(
  parameter int MS_CYCLES = `SHS_MS_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // machine sensor and encoder pins
  input wire logic homeLimitSwitch,
  input wire logic positiveTravelLimit,
  input wire logic negativeTravelLimit,
  input wire logic encoderIndex,
  input wire logic encoderStep,
  input wire logic encoderForward,
  input wire logic motorStalled,
  input wire logic presetInput,
  input wire logic interruptInput,
  // motion command
  output logic motionRun,
  output logic motionForward,
  output logic creepSpeed,
  output logic decelActive,
  output shs_torque_e torqueSelect,
  output logic homingComplete
);
  localparam int TENTH_CYC = `SHS_TENTH_MS_CYC;

  // ==========================================================
  // helpers
  function automatic logic [31:0] absDiff(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = {a[31], a} - {b[31], b};
    absDiff = d[32] ? 32'(-d) : d[31:0];
  endfunction

  // ==========================================================
  // pin synchronisers and edge detect
  logic [8:0] pinRaw, pinMeta_q, pinSync_q, pinLast_q;
  assign pinRaw = {interruptInput, presetInput, motorStalled, encoderForward, encoderStep,
                   encoderIndex, negativeTravelLimit, positiveTravelLimit, homeLimitSwitch};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= 9'h000;
      pinSync_q <= 9'h000;
      pinLast_q <= 9'h000;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end
  logic [8:0] pinRise, pinFall;
  assign pinRise = pinSync_q & ~pinLast_q;
  assign pinFall = ~pinSync_q & pinLast_q;
  shs_cfg_s staged_q, act_q;
  shs_state_e state_q;
  logic lsEvent, stepEvent, presetEvent, intEvent;
  assign lsEvent = act_q.switchEdge ? pinFall[0] : pinRise[0];
  assign stepEvent = pinRise[4];
  assign presetEvent = pinRise[7];
  assign intEvent = pinRise[8];

  // ==========================================================
  // apb registers
  logic [31:0] ctrl_q, home_q, win_q, decel_q, preset_q, intAmt_q, stpTime_q, stpTrq_q;
  logic [31:0] shift_q, revAmt_q;
  logic wrEn, rdEn, mapped;
  logic [31:0] rdData;
  assign wrEn = psel && penable && pwrite && pready;
  assign rdEn = psel && penable && !pready;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 32'h0;
      staged_q <= shs_cfg_s'(`SHS_CFG_RESET);
      home_q <= 32'h0;
      win_q <= 32'h0;
      decel_q <= `SHS_DECEL_RESET;
      preset_q <= 32'h0;
      intAmt_q <= `SHS_INTAMT_RESET;
      stpTime_q <= 32'h0;
      stpTrq_q <= 32'h0;
      shift_q <= `SHS_SHIFT_RESET;
      revAmt_q <= 32'h0;
    end else if (wrEn) begin
      case (paddr)
        `SHS_OFS_CTRL: ctrl_q <= pwdata & 32'h0000_0005;
        `SHS_OFS_CFG: staged_q <= shs_cfg_s'(pwdata[10:0]);
        `SHS_OFS_HOME: home_q <= pwdata;
        `SHS_OFS_WIN: win_q <= pwdata;
        `SHS_OFS_DECEL: decel_q <= pwdata;
        `SHS_OFS_PRESET: preset_q <= pwdata;
        `SHS_OFS_INTAMT: intAmt_q <= pwdata;
        `SHS_OFS_STPTIME: stpTime_q <= pwdata;
        `SHS_OFS_STPTRQ: stpTrq_q <= {25'h0, pwdata[6:0]};
        `SHS_OFS_SHIFT: shift_q <= pwdata;
        `SHS_OFS_REVAMT: revAmt_q <= pwdata;
        default: ;
      endcase
    end
  end
  // marked settings are held in a staged copy; only a CTRL write with the reload bit set while idle moves them into use
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= shs_cfg_s'(`SHS_CFG_RESET);
    end else if (wrEn && paddr == `SHS_OFS_CTRL && pwdata[`SHS_CTRL_RELOAD] && state_q == ST_IDLE) begin
      act_q <= staged_q;
    end
  end
  logic signed [31:0] pos_q, refPos_q, homePos_q, target_q;
  logic done_q, cancelled_q, reversed_q;
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `SHS_OFS_CTRL: rdData = ctrl_q;
      `SHS_OFS_CFG: rdData = {21'h0, staged_q};
      `SHS_OFS_HOME: rdData = home_q;
      `SHS_OFS_WIN: rdData = win_q;
      `SHS_OFS_DECEL: rdData = decel_q;
      `SHS_OFS_PRESET: rdData = preset_q;
      `SHS_OFS_INTAMT: rdData = intAmt_q;
      `SHS_OFS_STPTIME: rdData = stpTime_q;
      `SHS_OFS_STPTRQ: rdData = stpTrq_q;
      `SHS_OFS_SHIFT: rdData = shift_q;
      `SHS_OFS_REVAMT: rdData = revAmt_q;
      `SHS_OFS_STATUS: rdData = {16'h0, 5'h0, 3'(state_q), 5'h0, cancelled_q, done_q, homingComplete};
      `SHS_OFS_POS: rdData = pos_q;
      default: begin
        rdData = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= rdEn;
      pslverr <= rdEn && !pwrite && !mapped;
      if (rdEn && !pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // ==========================================================
  // reference events
  logic reqLast_q, startReq;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqLast_q <= 1'b0;
    end else begin
      reqLast_q <= ctrl_q[`SHS_CTRL_REQ];
    end
  end
  assign startReq = ctrl_q[`SHS_CTRL_REQ] && !reqLast_q;
  logic [31:0] timer_q;
  logic stallTimeout;
  logic shiftEvent, decelEvent;
  always_comb begin
    case (act_q.shiftRef)
      REF_SWITCH: shiftEvent = lsEvent;
      REF_INDEX: shiftEvent = pinRise[3];
      REF_POS_LIMIT: shiftEvent = pinRise[1];
      REF_NEG_LIMIT: shiftEvent = pinRise[2];
      REF_INTERRUPT: shiftEvent = intEvent;
      REF_STOPPER: shiftEvent = stallTimeout;
      default: shiftEvent = 1'b0;
    endcase
    case (act_q.decelRef)
      2'd1: decelEvent = pinRise[1];
      2'd2: decelEvent = pinRise[2];
      default: decelEvent = lsEvent;
    endcase
  end
  logic limitAhead;
  assign limitAhead = motionForward ? pinSync_q[1] : pinSync_q[2];

  // ==========================================================
  // position counter
  // a reference edge that lands with a step must latch the stepped position
  logic signed [31:0] posNext;
  assign posNext = !stepEvent ? pos_q : pinSync_q[5] ? pos_q + 32'sh1 : pos_q - 32'sh1;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 32'sh0;
    end else if (state_q == ST_SHIFT && absDiff(pos_q, refPos_q) >= shift_q) begin
      pos_q <= home_q;
    end else if (presetEvent) begin
      pos_q <= preset_q;
    end else if (stepEvent) begin
      pos_q <= posNext;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      motionRun <= 1'b0;
      motionForward <= 1'b1;
      creepSpeed <= 1'b0;
      decelActive <= 1'b0;
      torqueSelect <= TRQ_NORMAL;
      refPos_q <= 32'sh0;
      target_q <= 32'sh0;
      timer_q <= 32'h0;
      done_q <= 1'b0;
      cancelled_q <= 1'b0;
      reversed_q <= 1'b0;
      homePos_q <= 32'sh0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          motionRun <= 1'b0;
          decelActive <= 1'b0;
          if (startReq) begin
            done_q <= 1'b0;
            cancelled_q <= 1'b0;
            reversed_q <= 1'b0;
            motionRun <= 1'b1;
            torqueSelect <= TRQ_NORMAL;
            creepSpeed <= 1'b0;
            case (act_q.startDir)
              2'd1: motionForward <= 1'b0;
              2'd2: motionForward <= !pinSync_q[1];
              default: motionForward <= 1'b1;
            endcase
            refPos_q <= pos_q;
            if (act_q.shiftRef == REF_STOPPER) begin
              torqueSelect <= TRQ_STOPPER;
            end
            if (revAmt_q != 32'h0) begin
              motionForward <= act_q.startDir == 2'd0 ? 1'b0 : 1'b1;
              state_q <= ST_REVERSE;
            end else begin
              state_q <= ST_SEARCH;
            end
          end else if (ctrl_q[`SHS_CTRL_INTARM] && intEvent) begin
            target_q <= pos_q + intAmt_q;
            motionForward <= 1'b1;
            motionRun <= 1'b1;
            state_q <= ST_INTPOS;
          end
        end
        ST_REVERSE: begin
          if (shiftEvent || decelEvent) begin
            refPos_q <= posNext;
            motionForward <= act_q.homingDir == 1'b0;
            creepSpeed <= 1'b1;
            state_q <= shiftEvent ? ST_SHIFT : ST_CREEP;
          end else if (absDiff(pos_q, refPos_q) >= revAmt_q) begin
            motionForward <= !motionForward;
            state_q <= ST_SEARCH;
          end
        end
        ST_SEARCH, ST_CREEP: begin
          if (limitAhead && !(act_q.shiftRef inside {REF_POS_LIMIT, REF_NEG_LIMIT})) begin
            if (act_q.limitReaction || reversed_q) begin
              motionRun <= 1'b0;
              torqueSelect <= TRQ_THIRD;
              cancelled_q <= 1'b1;
              done_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              decelActive <= 1'b1;
              timer_q <= decel_q * 32'(TENTH_CYC);
              state_q <= ST_LIMIT_DECEL;
            end
          end else if (shiftEvent && (act_q.shiftRef != REF_INDEX || state_q == ST_CREEP)) begin
            refPos_q <= posNext;
            if (act_q.creepReverse && state_q == ST_SEARCH) begin
              motionForward <= act_q.homingDir;
              state_q <= ST_BACKUP;
            end else begin
              motionForward <= act_q.homingDir == 1'b0;
              state_q <= ST_SHIFT;
            end
          end else if (act_q.shiftRef == REF_INDEX && decelEvent) begin
            creepSpeed <= 1'b1;
            motionForward <= act_q.homingDir == 1'b0;
            state_q <= ST_CREEP;
          end
        end
        ST_BACKUP: begin
          if (absDiff(pos_q, refPos_q) >= 32'(`SHS_BACKUP_MARGIN)) begin
            creepSpeed <= 1'b1;
            motionForward <= act_q.homingDir == 1'b0;
            state_q <= ST_CREEP;
          end
        end
        ST_LIMIT_DECEL: begin
          // leave on the last counted cycle so the slow-down lasts exactly the set time
          if (timer_q <= 32'h1) begin
            decelActive <= 1'b0;
            motionForward <= !motionForward;
            reversed_q <= 1'b1;
            state_q <= ST_SEARCH;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        ST_SHIFT: begin
          if (absDiff(pos_q, refPos_q) >= shift_q) begin
            motionRun <= 1'b0;
            creepSpeed <= 1'b0;
            torqueSelect <= TRQ_NORMAL;
            homePos_q <= home_q;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_INTPOS: begin
          if (pos_q >= target_q) begin
            motionRun <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // stopper contact: stall must persist for the detect time under the stopper torque limit
  logic [31:0] stallCnt_q, stallMs_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stallCnt_q <= 32'h0;
      stallMs_q <= 32'h0;
    end else if (!(pinSync_q[6] && torqueSelect == TRQ_STOPPER)) begin
      stallCnt_q <= 32'h0;
      stallMs_q <= 32'h0;
    end else if (stallCnt_q == 32'(MS_CYCLES - 1)) begin
      stallCnt_q <= 32'h0;
      stallMs_q <= stallMs_q + 32'h1;
    end else begin
      stallCnt_q <= stallCnt_q + 32'h1;
    end
  end
  assign stallTimeout = torqueSelect == TRQ_STOPPER && pinSync_q[6] && stallMs_q >= stpTime_q;

  // completion output qualified by the position window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      homingComplete <= 1'b0;
    end else begin
      homingComplete <= done_q && (win_q == 32'h0 || absDiff(pos_q, homePos_q) <= win_q);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_home_load: assert property (state_q == ST_SHIFT && absDiff(pos_q, refPos_q) >= shift_q
    |=> pos_q == $past(home_q)) else $error("home coordinate not loaded");
  a_window_gate: assert property (done_q && win_q != 32'h0 && absDiff(pos_q, homePos_q) > win_q
    |=> !homingComplete) else $error("complete outside window");
  a_window_zero: assert property (done_q && win_q == 32'h0 |=> homingComplete)
    else $error("complete missing with zero window");
  a_limit_stop: assert property (state_q == ST_SEARCH && limitAhead && act_q.limitReaction
    && !(act_q.shiftRef inside {REF_POS_LIMIT, REF_NEG_LIMIT})
    |=> !motionRun && torqueSelect == TRQ_THIRD && cancelled_q) else $error("no stop at limit");
  a_decel_flip: assert property (state_q == ST_LIMIT_DECEL && timer_q <= 32'h1
    |=> motionForward != $past(motionForward) && state_q == ST_SEARCH) else $error("no reverse");
  a_preset_load: assert property (presetEvent && state_q != ST_SHIFT |=> pos_q == $past(preset_q))
    else $error("preset not loaded");
  a_start_run: assert property (state_q == ST_IDLE && startReq |=> motionRun && !done_q)
    else $error("request did not start");
  a_stopper_only: assert property (act_q.shiftRef != REF_STOPPER |-> torqueSelect != TRQ_STOPPER)
    else $error("stopper limit outside stopper mode");
  c_homed: cover property (state_q == ST_SHIFT ##[1:1000] done_q);
  c_limit_rev: cover property (state_q == ST_LIMIT_DECEL ##1 decelActive);
  c_cancel: cover property ($rose(cancelled_q));
  c_intpos: cover property (state_q == ST_INTPOS ##1 !motionRun);
endmodule

// ### verif/shs_motor_model.sv
// behavioural motor, encoder and machine sensors beside the homing sequencer
`timescale 1ns/10ps
module shs_motor_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // motion command and bench controls
  input wire logic motionRun,
  input wire logic motionForward,
  input wire logic jog,
  input wire logic signed [31:0] posLimitAt,
  // sensor pins
  output logic homeLimitSwitch,
  output logic positiveTravelLimit,
  output logic negativeTravelLimit,
  output logic encoderIndex,
  output logic encoderStep,
  output logic encoderForward,
  output logic motorStalled,
  output logic signed [31:0] pos
);
  logic [3:0] tick;
  logic moving;
  // ==========
  // stepping
  // direction settles one clock ahead of the step edge, so it is never sampled mid-change
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 4'h0;
      moving <= 1'b0;
      encoderStep <= 1'b0;
      encoderForward <= 1'b1;
      pos <= 32'sh0;
    end else begin
      tick <= tick + 4'h1;
      if (tick == 4'hf) begin
        moving <= motionRun | jog;
        encoderForward <= jog | motionForward;
      end
      if (tick == 4'h0 && moving) begin
        encoderStep <= 1'b1;
        pos <= encoderForward ? pos + 32'sh1 : pos - 32'sh1;
      end
      if (tick == 4'h4) begin
        encoderStep <= 1'b0;
      end
    end
  end
  // ==========
  // sensors
  assign homeLimitSwitch = (pos >= 32'sh64) && (pos <= 32'shc7);
  assign positiveTravelLimit = pos >= posLimitAt;
  assign negativeTravelLimit = pos <= -32'sh3e8;
  assign encoderIndex = pos[4:0] == 5'h0;
  // stall only matters for stopper homing, which this partner does not model
  assign motorStalled = 1'b0;
endmodule

// ### verif/shs_homing_sequencer_bench.sv
// self-checking bench for the homing sequencer
`timescale 1ns/10ps
`include "shs_map.svh"
module shs_homing_sequencer_bench import shs_pkg::*;;
  localparam int CYCLE_LIMIT = 40000;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, homeLimitSwitch, positiveTravelLimit, negativeTravelLimit;
  logic encoderIndex, encoderStep, encoderForward, motorStalled;
  logic presetInput = 1'b0;
  logic interruptInput = 1'b0;
  logic jog = 1'b0;
  logic signed [31:0] posLimitAt = 32'sh7fff_ffff;
  logic signed [31:0] partnerPos;
  logic motionRun, motionForward, creepSpeed, decelActive, homingComplete;
  shs_torque_e torqueSelect;
  int errorCnt = 0;
  int checked = 0;
  int cycleCnt = 0;
  always #12.5 ref_clk = ~ref_clk;
  shs_homing_sequencer #(.MS_CYCLES(4)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .homeLimitSwitch(homeLimitSwitch), .positiveTravelLimit(positiveTravelLimit),
    .negativeTravelLimit(negativeTravelLimit), .encoderIndex(encoderIndex), .encoderStep(encoderStep),
    .encoderForward(encoderForward), .motorStalled(motorStalled), .presetInput(presetInput),
    .interruptInput(interruptInput), .motionRun(motionRun), .motionForward(motionForward),
    .creepSpeed(creepSpeed), .decelActive(decelActive), .torqueSelect(torqueSelect),
    .homingComplete(homingComplete));
  shs_motor_model motor (.ref_clk(ref_clk), .arst_n(arst_n), .motionRun(motionRun), .motionForward(motionForward),
    .jog(jog), .posLimitAt(posLimitAt), .homeLimitSwitch(homeLimitSwitch), .positiveTravelLimit(positiveTravelLimit),
    .negativeTravelLimit(negativeTravelLimit), .encoderIndex(encoderIndex), .encoderStep(encoderStep),
    .encoderForward(encoderForward), .motorStalled(motorStalled), .pos(partnerPos));
  // ==========
  // reporting
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == CYCLE_LIMIT) begin
      errorCnt++;
      conclude();
    end
  end
  // ==========
  // apb master and helpers
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                          output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wait_level(ref logic sig, input logic lvl, input int lim);
    for (int i = 0; i < lim && sig !== lvl; i++) @(posedge ref_clk);
  endtask
  task automatic jog_to(input logic signed [31:0] target);
    jog <= 1'b1;
    for (int i = 0; i < 200 && partnerPos !== target; i++) @(posedge ref_clk);
    jog <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // ==========
  // scenarios
  task automatic t_reset_regs();
    logic [7:0] adr [8] = '{`SHS_OFS_CFG, `SHS_OFS_DECEL, `SHS_OFS_SHIFT, `SHS_OFS_INTAMT, `SHS_OFS_HOME,
                            `SHS_OFS_WIN, `SHS_OFS_PRESET, 8'hfc};
    logic [31:0] exp [8] = '{32'h4, 32'h3e8, 32'h3e8, 32'h186a0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] d;
    logic e;
    chk_bit(motionForward, 1'b1);
    chk_bit(motionRun, 1'b0);
    for (int i = 0; i < 8; i++) begin
      apb_xfer(1'b0, adr[i], 32'h0, d, e);
      chk_word(d, exp[i]);
      chk_bit(e, i == 7);
    end
    apb_wr(`SHS_OFS_POS, 32'h1234);
    apb_xfer(1'b0, `SHS_OFS_POS, 32'h0, d, e);
    chk_word(d, 32'h0);
  endtask
  task automatic t_interrupt();
    logic signed [31:0] p0;
    logic [31:0] d;
    logic e;
    apb_wr(`SHS_OFS_INTAMT, 32'ha);
    apb_wr(`SHS_OFS_CTRL, 32'h4);
    for (int i = 0; i < 40 && encoderStep !== 1'b1; i++) @(posedge ref_clk);
    @(posedge ref_clk);
    interruptInput <= 1'b1;
    p0 = partnerPos;
    repeat (4) @(posedge ref_clk);
    interruptInput <= 1'b0;
    wait_level(motionRun, 1'b1, 100);
    wait_level(motionRun, 1'b0, 2000);
    repeat (20) @(posedge ref_clk);
    apb_xfer(1'b0, `SHS_OFS_POS, 32'h0, d, e);
    chk_word(d, p0 + 32'sha);
    chk_word(partnerPos, p0 + 32'sha);
    apb_wr(`SHS_OFS_CTRL, 32'h0);
  endtask
  task automatic t_preset();
    logic [31:0] d;
    logic e;
    apb_wr(`SHS_OFS_PRESET, 32'hffff_fff9);
    presetInput <= 1'b1;
    repeat (4) @(posedge ref_clk);
    presetInput <= 1'b0;
    repeat (6) @(posedge ref_clk);
    apb_xfer(1'b0, `SHS_OFS_POS, 32'h0, d, e);
    chk_word(d, 32'hffff_fff9);
  endtask
  task automatic t_home();
    logic [31:0] d;
    logic e;
    apb_wr(`SHS_OFS_CFG, 32'h4);
    apb_wr(`SHS_OFS_CTRL, 32'h2);
    apb_wr(`SHS_OFS_SHIFT, 32'h14);
    apb_wr(`SHS_OFS_HOME, 32'hffff_fffb);
    apb_wr(`SHS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk_bit(motionRun, 1'b1);
    chk_bit(motionForward, 1'b1);
    chk_bit(creepSpeed, 1'b0);
    wait_level(homingComplete, 1'b1, 5000);
    chk_bit(homingComplete, 1'b1);
    chk_bit(motionRun, 1'b0);
    chk_word(partnerPos, 32'sh94);
    apb_xfer(1'b0, `SHS_OFS_POS, 32'h0, d, e);
    chk_word(d, 32'hffff_fffb);
  endtask
  task automatic t_window();
    apb_wr(`SHS_OFS_WIN, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk_bit(homingComplete, 1'b1);
    jog_to(32'sh97);
    chk_bit(homingComplete, 1'b1);
    jog_to(32'sh98);
    chk_bit(homingComplete, 1'b0);
    apb_wr(`SHS_OFS_WIN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk_bit(homingComplete, 1'b1);
    apb_wr(`SHS_OFS_CTRL, 32'h0);
    apb_wr(`SHS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk_bit(homingComplete, 1'b0);
  endtask
  task automatic t_limit_reverse();
    int n;
    do_reset();
    posLimitAt <= 32'sh3c;
    apb_wr(`SHS_OFS_CFG, 32'h404);
    apb_wr(`SHS_OFS_DECEL, 32'h1);
    apb_wr(`SHS_OFS_CTRL, 32'h1);
    wait_level(decelActive, 1'b1, 2000);
    n = 0;
    while (decelActive === 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    chk_word(n, 32'd4000);
    repeat (2) @(posedge ref_clk);
    chk_bit(motionForward, 1'b0);
    chk_bit(motionRun, 1'b1);
  endtask
  task automatic t_limit_stop();
    logic [31:0] d;
    logic e;
    do_reset();
    apb_wr(`SHS_OFS_CFG, 32'h404);
    apb_wr(`SHS_OFS_CTRL, 32'h2);
    apb_wr(`SHS_OFS_CTRL, 32'h1);
    wait_level(motionRun, 1'b1, 20);
    wait_level(motionRun, 1'b0, 2000);
    chk_word({30'h0, torqueSelect}, {30'h0, TRQ_THIRD});
    chk_bit(homingComplete, 1'b0);
    apb_xfer(1'b0, `SHS_OFS_STATUS, 32'h0, d, e);
    chk_bit(d[2], 1'b1);
    chk_bit(motionRun, 1'b0);
  endtask
  initial begin
    do_reset();
    t_reset_regs();
    t_interrupt();
    t_preset();
    t_home();
    t_window();
    t_limit_reverse();
    t_limit_stop();
    conclude();
  end
endmodule
